// File: hw/rtf_cfg.svh
// constants for the radio transmit/receive data fifo
`ifndef RTF_CFG_SVH
`define RTF_CFG_SVH
`define RTF_DEPTH 128
`define RTF_FIFO_ADDR 8'hff
`define RTF_SLEEP_CFG_ADDR 8'h79
`define RTF_SLEEP_SEL_BIT 0
`define RTF_TX_AF_OFFSET 8'h02
`define RTF_ST_TX_FULL 8
`define RTF_ST_RX_EMPTY 9
`define RTF_PN9_SEED 9'h1ff
`define RTF_DCLK_DIV 8'h04
`endif

// File: hw/rtf_device.sv
// device end: tx and rx byte fifos, thresholds, errors, data sources
`timescale 1ns/10ps
`include "rtf_cfg.svh"
module rtf_device #(
	parameter int DEPTH = `RTF_DEPTH
) (
	// clock and reset
	input wire logic CORE_CLK_IN,
	input wire logic RESET_N_IN,
	// link to host
	rtf_link_if.device LINK,
	// configuration
	input wire rtf_pkg::rtf_mode_e MODE_IN,
	input wire logic [7:0] TX_FREE_SPACE_THRESHOLD_IN,
	input wire logic [7:0] TX_LOW_LEVEL_THRESHOLD_IN,
	input wire logic [7:0] RX_FREE_SPACE_THRESHOLD_IN,
	input wire logic [7:0] RX_LOW_LEVEL_THRESHOLD_IN,
	input wire logic THRESHOLD_IRQ_FIFO_SELECT_IN,
	input wire logic [3:0] MAX_RETRANSMIT_COUNT_IN,
	// modem side
	input wire logic TX_BYTE_REQ_IN,
	input wire logic TX_PACKET_END_IN,
	input wire logic RX_BYTE_VALID_IN,
	input wire rtf_pkg::rtf_byte_t RX_BYTE_IN,
	output logic [7:0] TX_BYTE_OUT,
	output logic TX_BIT_OUT,
	output logic TX_BIT_VALID_OUT,
	// status and events
	output logic [15:0] CONTROLLER_STATE_STATUS_OUT,
	output logic [7:0] SLEEP_RETENTION_CONFIG_OUT,
	output logic TX_ALMOST_FULL_IRQ_OUT,
	output logic TX_ALMOST_EMPTY_IRQ_OUT,
	output logic RX_ALMOST_FULL_IRQ_OUT,
	output logic RX_ALMOST_EMPTY_IRQ_OUT,
	output logic TX_ERROR_IRQ_OUT,
	output logic RX_ERROR_IRQ_OUT
);
	import rtf_pkg::*;
	if (DEPTH < 2 || DEPTH > 255 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
		$error("depth unsupported");
	end
	localparam int AW = $clog2(DEPTH);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [AW-1:0] tx_wp;
		logic [AW-1:0] tx_rp;
		logic [AW:0] tx_cnt;
		logic [AW-1:0] tx_base;
		logic [AW:0] tx_sent;
		logic [3:0] retx;
		logic [AW-1:0] rx_wp;
		logic [AW-1:0] rx_rp;
		logic [AW:0] rx_cnt;
		logic tx_err;
		logic rx_err;
		logic [7:0] last_byte;
		logic [7:0] rdata;
		logic [7:0] sleep_cfg;
		logic asleep;
		logic [8:0] pn9;
		logic [7:0] div;
		logic dclk;
		logic dbit_s1;
		logic dbit_s2;
		logic bit_out;
		logic bit_valid;
		logic [7:0] tx_byte;
	} rtf_dev_s;
	rtf_dev_s q, d;
	logic [7:0] tx_mem [DEPTH];
	logic [7:0] rx_mem [DEPTH];
	logic host_push, host_pop, tx_take, rx_put, tx_flush, rx_flush, tx_bad, rx_bad;
	logic [AW:0] tx_free, rx_free;

	assign host_push = LINK.wr && LINK.addr == `RTF_FIFO_ADDR;
	assign host_pop = LINK.rd && LINK.addr == `RTF_FIFO_ADDR;
	assign tx_take = TX_BYTE_REQ_IN && MODE_IN != RTF_MODE_DIRECT_PIN && MODE_IN != RTF_MODE_PN9;
	assign rx_put = RX_BYTE_VALID_IN;
	assign tx_flush = LINK.cmd == RTF_CMD_TX_FLUSH;
	assign rx_flush = LINK.cmd == RTF_CMD_RX_FLUSH;
	assign tx_bad = (host_push && q.tx_cnt == (AW+1)'(DEPTH)) || (tx_take && q.tx_cnt == '0);
	assign rx_bad = (rx_put && q.rx_cnt == (AW+1)'(DEPTH)) || (host_pop && q.rx_cnt == '0);
	assign tx_free = (AW+1)'(DEPTH) - q.tx_cnt;
	assign rx_free = (AW+1)'(DEPTH) - q.rx_cnt;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		d = q;
		// tx fill side; push into full fifo is an overflow
		if (host_push) begin
			if (q.tx_cnt == (AW+1)'(DEPTH)) begin
				d.tx_err = 1'b1;
			end else begin
				d.tx_wp = q.tx_wp + 1'b1;
				if (q.tx_sent != '0) begin
					d.retx = '0; // new data after a byte was sent resets the retransmit count
				end
			end
		end
		// tx drain side
		if (tx_take) begin
			if (q.tx_cnt == '0) begin
				d.tx_byte = q.last_byte; // repeat last byte
				d.tx_err = 1'b1;
			end else begin
				d.tx_byte = tx_mem[q.tx_rp]; // unchanged in direct fifo mode
				d.last_byte = tx_mem[q.tx_rp];
				d.tx_rp = q.tx_rp + 1'b1;
				d.tx_sent = q.tx_sent + 1'b1;
			end
		end
		d.tx_cnt = q.tx_cnt + (AW+1)'(host_push && q.tx_cnt != (AW+1)'(DEPTH))
			- (AW+1)'(tx_take && q.tx_cnt != '0);
		// packet end: rewind for replay if the packet fitted
		if (TX_PACKET_END_IN) begin
			if (q.retx < MAX_RETRANSMIT_COUNT_IN && q.tx_sent <= (AW+1)'(DEPTH)
				&& MODE_IN == RTF_MODE_PACKET) begin
				d.retx = q.retx + 1'b1;
				d.tx_rp = q.tx_base;
				d.tx_cnt = q.tx_sent + (AW+1)'(host_push);
			end else begin
				d.retx = '0;
				d.tx_base = q.tx_rp;
			end
			d.tx_sent = '0;
		end
		// rx side
		if (rx_put) begin
			if (q.rx_cnt == (AW+1)'(DEPTH)) begin
				d.rx_err = 1'b1;
			end else begin
				d.rx_wp = q.rx_wp + 1'b1;
			end
		end
		if (host_pop) begin
			if (q.rx_cnt == '0) begin
				d.rx_err = 1'b1; // underflow, data invalid
				d.rdata = '0;
			end else begin
				d.rdata = rx_mem[q.rx_rp];
				d.rx_rp = q.rx_rp + 1'b1;
			end
		end else if (LINK.rd && LINK.addr == `RTF_SLEEP_CFG_ADDR) begin
			d.rdata = q.sleep_cfg;
		end else if (LINK.rd) begin
			d.rdata = '0;
		end
		d.rx_cnt = q.rx_cnt + (AW+1)'(rx_put && q.rx_cnt != (AW+1)'(DEPTH))
			- (AW+1)'(host_pop && q.rx_cnt != '0);
		if (LINK.wr && LINK.addr == `RTF_SLEEP_CFG_ADDR) begin
			d.sleep_cfg = LINK.wdata;
		end
		// sleep without retention loses contents
		if (LINK.cmd == RTF_CMD_SLEEP) begin
			d.asleep = 1'b1;
		end else if (LINK.cmd == RTF_CMD_WAKE) begin
			d.asleep = 1'b0;
		end
		// flushes win, but an error in the same cycle stays set
		if (tx_flush || (LINK.cmd == RTF_CMD_SLEEP && !q.sleep_cfg[`RTF_SLEEP_SEL_BIT])) begin
			d.tx_wp = '0;
			d.tx_rp = '0;
			d.tx_cnt = '0;
			d.tx_base = '0;
			d.tx_sent = '0;
			d.retx = '0;
			d.tx_err = tx_bad;
		end
		if (rx_flush || (LINK.cmd == RTF_CMD_SLEEP && !q.sleep_cfg[`RTF_SLEEP_SEL_BIT])) begin
			d.rx_wp = '0;
			d.rx_rp = '0;
			d.rx_cnt = '0;
			d.rx_err = rx_bad;
		end
		// pin-fed and pn9 sources on a divided data clock
		d.bit_valid = 1'b0;
		d.dbit_s1 = LINK.dbit;
		d.dbit_s2 = q.dbit_s1;
		if (MODE_IN == RTF_MODE_DIRECT_PIN || MODE_IN == RTF_MODE_PN9) begin
			if (q.div == `RTF_DCLK_DIV - 8'h01) begin
				d.div = '0;
				d.dclk = !q.dclk;
				if (!q.dclk && MODE_IN == RTF_MODE_PN9) begin
					d.bit_valid = 1'b1;
					d.bit_out = q.pn9[0];
					d.pn9 = {q.pn9[0] ^ q.pn9[5], q.pn9[8:1]};
				end
			end else begin
				d.div = q.div + 8'h01;
			end
			// pin value at the rising edge leaves the synchroniser two cycles later
			if (q.dclk && q.div == 8'h02 && MODE_IN == RTF_MODE_DIRECT_PIN) begin
				d.bit_valid = 1'b1;
				d.bit_out = q.dbit_s2;
			end
		end else begin
			d.div = '0;
			d.dclk = 1'b0;
		end
	end

	// ----------------------------------------
	// registers and memories
	// ----------------------------------------
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RESET_N_IN) begin
			q <= '0;
			q.pn9 <= `RTF_PN9_SEED;
		end else begin
			q <= d;
		end
		if (host_push && q.tx_cnt != (AW+1)'(DEPTH)) begin
			tx_mem[q.tx_wp] <= LINK.wdata;
		end
		if (rx_put && q.rx_cnt != (AW+1)'(DEPTH)) begin
			rx_mem[q.rx_wp] <= RX_BYTE_IN;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign LINK.rdata = q.rdata;
	assign LINK.dclk = q.dclk;
	assign TX_BYTE_OUT = q.tx_byte;
	assign TX_BIT_OUT = q.bit_out;
	assign TX_BIT_VALID_OUT = q.bit_valid;
	assign SLEEP_RETENTION_CONFIG_OUT = q.sleep_cfg;
	always_comb begin
		CONTROLLER_STATE_STATUS_OUT = '0;
		CONTROLLER_STATE_STATUS_OUT[`RTF_ST_TX_FULL] = q.tx_cnt == (AW+1)'(DEPTH);
		CONTROLLER_STATE_STATUS_OUT[`RTF_ST_RX_EMPTY] = q.rx_cnt == '0;
		CONTROLLER_STATE_STATUS_OUT[0] = q.asleep;
	end
	assign TX_ALMOST_FULL_IRQ_OUT = !THRESHOLD_IRQ_FIFO_SELECT_IN
		&& {1'b0, tx_free} <= (AW+2)'(TX_FREE_SPACE_THRESHOLD_IN) - (AW+2)'(`RTF_TX_AF_OFFSET);
	assign TX_ALMOST_EMPTY_IRQ_OUT = !THRESHOLD_IRQ_FIFO_SELECT_IN
		&& q.tx_cnt <= (AW+1)'(TX_LOW_LEVEL_THRESHOLD_IN);
	assign RX_ALMOST_FULL_IRQ_OUT = THRESHOLD_IRQ_FIFO_SELECT_IN
		&& rx_free <= (AW+1)'(RX_FREE_SPACE_THRESHOLD_IN);
	assign RX_ALMOST_EMPTY_IRQ_OUT = THRESHOLD_IRQ_FIFO_SELECT_IN
		&& q.rx_cnt <= (AW+1)'(RX_LOW_LEVEL_THRESHOLD_IN);
	assign TX_ERROR_IRQ_OUT = q.tx_err;
	assign RX_ERROR_IRQ_OUT = q.rx_err;
endmodule : rtf_device

// File: hw/rtf_host.sv
// host end: drives fifo writes, reads, commands and pin-fed bits
`timescale 1ns/10ps
`include "rtf_cfg.svh"
module rtf_host (
	// clock and reset
	input wire logic CORE_CLK_IN,
	input wire logic RESET_N_IN,
	// user side
	input wire logic USER_WR_IN,
	input wire logic USER_RD_IN,
	input wire logic [7:0] USER_ADDR_IN,
	input wire logic [7:0] USER_WDATA_IN,
	input wire logic [2:0] USER_CMD_IN,
	input wire logic USER_BIT_IN,
	input wire logic TX_ERROR_IN,
	input wire logic RX_ERROR_IN,
	output logic [7:0] USER_RDATA_OUT,
	output logic BUSY_OUT,
	// link to device
	rtf_link_if.host LINK
);
	import rtf_pkg::*;
	typedef enum logic [1:0] {
		RTF_H_IDLE,
		RTF_H_FLUSH
	} rtf_host_e;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic [2:0] cmd;
		logic dbit;
		logic c1;
		logic c2;
		logic c3;
		logic rd_d;
		logic [7:0] rdata;
		logic tx_bad;
		rtf_host_e st;
	} rtf_host_s;
	rtf_host_s q, d;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		d = q;
		d.wr = 1'b0;
		d.rd = 1'b0;
		d.cmd = RTF_CMD_NONE;
		d.c1 = LINK.dclk;
		d.c2 = q.c1;
		d.c3 = q.c2;
		d.rd_d = q.rd;
		if (q.rd_d) begin
			d.rdata = LINK.rdata;
		end
		// new bit after a falling data clock, stable at rising
		if (q.c3 && !q.c2) begin
			d.dbit = USER_BIT_IN;
		end
		case (q.st)
			RTF_H_IDLE: begin
				if (TX_ERROR_IN || RX_ERROR_IN) begin
					d.cmd = RTF_CMD_ABORT;
					d.tx_bad = TX_ERROR_IN;
					d.st = RTF_H_FLUSH;
				end else if (USER_CMD_IN != 3'h0) begin
					d.cmd = USER_CMD_IN;
				end else begin
					d.wr = USER_WR_IN;
					d.rd = USER_RD_IN && !USER_WR_IN;
					d.addr = USER_ADDR_IN;
					d.wdata = USER_WDATA_IN;
				end
			end
			RTF_H_FLUSH: begin
				d.cmd = q.tx_bad ? RTF_CMD_TX_FLUSH : RTF_CMD_RX_FLUSH;
				d.st = RTF_H_IDLE;
			end
			default: begin
				d.st = RTF_H_IDLE;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (!RESET_N_IN) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign LINK.wr = q.wr;
	assign LINK.rd = q.rd;
	assign LINK.addr = q.addr;
	assign LINK.wdata = q.wdata;
	assign LINK.cmd = q.cmd;
	assign LINK.dbit = q.dbit;
	assign USER_RDATA_OUT = q.rdata;
	assign BUSY_OUT = q.st != RTF_H_IDLE || TX_ERROR_IN || RX_ERROR_IN;
endmodule : rtf_host

// File: hw/rtf_link_if.sv
// link between host and radio data fifo block
`timescale 1ns/10ps
interface rtf_link_if;
	logic wr;
	logic rd;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic [2:0] cmd;
	logic dclk;
	logic dbit;
	modport device (input wr, rd, addr, wdata, cmd, dbit, output rdata, dclk);
	modport host (output wr, rd, addr, wdata, cmd, dbit, input rdata, dclk);
endinterface : rtf_link_if

// File: hw/rtf_pkg.sv
// types shared by both ends of the data fifo link
package rtf_pkg;
	typedef enum logic [1:0] {
		RTF_MODE_PACKET,
		RTF_MODE_DIRECT_FIFO,
		RTF_MODE_DIRECT_PIN,
		RTF_MODE_PN9
	} rtf_mode_e;
	typedef enum logic [2:0] {
		RTF_CMD_NONE,
		RTF_CMD_ABORT,
		RTF_CMD_TX_FLUSH,
		RTF_CMD_RX_FLUSH,
		RTF_CMD_SLEEP,
		RTF_CMD_WAKE
	} rtf_cmd_e;
	typedef logic [7:0] rtf_byte_t;
endpackage : rtf_pkg

// File: test/rtf_link_properties.sv
// link checker: concurrent properties on the host to device fifo link
`timescale 1ns/10ps
module rtf_link_checker (
	// clock and reset
	input wire logic CORE_CLK_IN,
	input wire logic RESET_N_IN,
	// link signals
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic [2:0] cmd,
	input wire logic dclk,
	input wire logic dbit
);
	import rtf_pkg::*;
	logic [7:0] cfg_q;
	default clocking @(posedge CORE_CLK_IN);
	endclocking
	default disable iff (!RESET_N_IN);
	// mirror of the retention register
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RESET_N_IN) begin
			cfg_q <= 8'h00;
		end else if (wr && addr == 8'h79) begin
			cfg_q <= wdata;
		end
	end
	// ----------
	// properties
	// ----------
	property p_no_wr_rd;
		!(wr && rd);
	endproperty
	a_no_wr_rd: assert property (p_no_wr_rd)
		else $error("strobes overlap");
	property p_other_zero;
		rd && addr != 8'hff && addr != 8'h79 |=> rdata == 8'h00;
	endproperty
	a_other_zero: assert property (p_other_zero)
		else $error("unmapped read not zero");
	property p_cfg_back;
		rd && addr == 8'h79 |=> rdata == cfg_q;
	endproperty
	a_cfg_back: assert property (p_cfg_back)
		else $error("retention readback wrong");
	property p_rdata_hold;
		$changed(rdata) |-> $past(rd);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold)
		else $error("read data moved without read");
	property p_flush_empty;
		cmd == RTF_CMD_RX_FLUSH ##1 (rd && addr == 8'hff) |=> rdata == 8'h00;
	endproperty
	a_flush_empty: assert property (p_flush_empty)
		else $error("pop after flush not empty");
	property p_dclk_period;
		$rose(dclk) |-> ##8 $rose(dclk);
	endproperty
	a_dclk_period: assert property (p_dclk_period)
		else $error("data clock period wrong");
	property p_dbit_stable;
		$rose(dclk) |-> $stable(dbit);
	endproperty
	a_dbit_stable: assert property (p_dbit_stable)
		else $error("bit moved at clock edge");
	property p_cmd_legal;
		cmd <= 3'h5;
	endproperty
	a_cmd_legal: assert property (p_cmd_legal)
		else $error("illegal command code");
endmodule : rtf_link_checker

// File: test/test_radio_tx_rx_data_fifo.sv
// bench: host and device ends of the data fifo joined over the link
`timescale 1ns/10ps
module test_radio_tx_rx_data_fifo;
	import rtf_pkg::*;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic u_wr = 1'h0, u_rd = 1'h0, u_bit = 1'h0, sel = 1'h0;
	logic tx_req = 1'h0, tx_end = 1'h0, rx_vld = 1'h0;
	logic [7:0] u_addr = 8'h00, u_wdata = 8'h00, rx_byte = 8'h00, nxt = 8'h00, v;
	logic [2:0] u_cmd = 3'h0;
	logic [3:0] retx = 4'h0;
	rtf_mode_e mode = RTF_MODE_PACKET;
	logic [7:0] tx_byte, slp_cfg, u_rdata;
	logic [15:0] status;
	logic tx_bit, tx_vld, taf, tae, raf, rae, terr, rerr, busy;
	int num_errors = 0;
	int check_count = 0;
	int n;
	rtf_link_if link();
	rtf_device rtf_device_inst (.CORE_CLK_IN(clk), .RESET_N_IN(rst_n), .LINK(link),
		.MODE_IN(mode), .TX_FREE_SPACE_THRESHOLD_IN(8'h0a), .TX_LOW_LEVEL_THRESHOLD_IN(8'h01),
		.RX_FREE_SPACE_THRESHOLD_IN(8'h7e), .RX_LOW_LEVEL_THRESHOLD_IN(8'h01),
		.THRESHOLD_IRQ_FIFO_SELECT_IN(sel), .MAX_RETRANSMIT_COUNT_IN(retx),
		.TX_BYTE_REQ_IN(tx_req), .TX_PACKET_END_IN(tx_end), .RX_BYTE_VALID_IN(rx_vld),
		.RX_BYTE_IN(rx_byte), .TX_BYTE_OUT(tx_byte), .TX_BIT_OUT(tx_bit),
		.TX_BIT_VALID_OUT(tx_vld), .CONTROLLER_STATE_STATUS_OUT(status),
		.SLEEP_RETENTION_CONFIG_OUT(slp_cfg), .TX_ALMOST_FULL_IRQ_OUT(taf),
		.TX_ALMOST_EMPTY_IRQ_OUT(tae), .RX_ALMOST_FULL_IRQ_OUT(raf),
		.RX_ALMOST_EMPTY_IRQ_OUT(rae), .TX_ERROR_IRQ_OUT(terr), .RX_ERROR_IRQ_OUT(rerr));
	rtf_host rtf_host_inst (.CORE_CLK_IN(clk), .RESET_N_IN(rst_n), .USER_WR_IN(u_wr),
		.USER_RD_IN(u_rd), .USER_ADDR_IN(u_addr), .USER_WDATA_IN(u_wdata), .USER_CMD_IN(u_cmd),
		.USER_BIT_IN(u_bit), .TX_ERROR_IN(terr), .RX_ERROR_IN(rerr), .USER_RDATA_OUT(u_rdata),
		.BUSY_OUT(busy), .LINK(link));
	rtf_link_checker rtf_link_checker_inst (.CORE_CLK_IN(clk), .RESET_N_IN(rst_n),
		.wr(link.wr), .rd(link.rd), .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata),
		.cmd(link.cmd), .dclk(link.dclk), .dbit(link.dbit));
	// -------
	// helpers
	// -------
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : tick
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic chkb(input logic g, input logic e);
		chk({7'h00, g}, {7'h00, e});
	endtask : chkb
	task automatic op(input logic w, r, input logic [7:0] a, d, input logic [2:0] c);
		@(posedge clk);
		u_wr <= w;
		u_rd <= r;
		u_addr <= a;
		u_wdata <= d;
		u_cmd <= c;
	endtask : op
	task automatic idle;
		op(1'h0, 1'h0, 8'h00, 8'h00, 3'h0);
		tick(3);
	endtask : idle
	task automatic send(input logic [2:0] c);
		op(1'h0, 1'h0, 8'h00, 8'h00, c);
		idle();
	endtask : send
	task automatic push(input int k);
		for (int i = 0; i < k; i++) begin
			op(1'h1, 1'h0, 8'hff, nxt, 3'h0);
			nxt = nxt + 8'h01;
		end
		idle();
	endtask : push
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		op(1'h0, 1'h1, a, 8'h00, 3'h0);
		idle();
		chk(u_rdata, e);
	endtask : rd
	task automatic pull(input logic [7:0] e);
		@(posedge clk);
		tx_req <= 1'h1;
		@(posedge clk);
		tx_req <= 1'h0;
		tick(1);
		chk(tx_byte, e);
	endtask : pull
	task automatic feed(input logic [7:0] b);
		@(posedge clk);
		rx_vld <= 1'h1;
		rx_byte <= b;
		@(posedge clk);
		rx_vld <= 1'h0;
	endtask : feed
	task automatic recover(input logic [2:0] c);
		tick(3);
		for (n = 0; n < 50 && busy !== 1'h0; n++)
			tick(1);
		chkb(busy, 1'h0);
		send(RTF_CMD_ABORT);
		send(c);
	endtask : recover
	task automatic slp;
		send(RTF_CMD_SLEEP);
		chkb(status[0], 1'h1);
		send(RTF_CMD_WAKE);
	endtask : slp
	// ---------
	// scenarios
	// ---------
	task automatic t_regs;
		rd(8'h79, 8'h00);
		op(1'h1, 1'h0, 8'h79, 8'h01, 3'h0);
		idle();
		rd(8'h79, 8'h01);
		chk(slp_cfg, 8'h01);
		rd(8'h10, 8'h00);
	endtask : t_regs
	task automatic t_fill;
		push(119);
		chkb(taf, 1'h0);
		push(1);
		chkb(taf, 1'h1);
		push(8);
		chkb(status[8], 1'h1);
		push(1);
		chkb(terr, 1'h1);
		recover(RTF_CMD_TX_FLUSH);
		chkb(status[8], 1'h0);
		chkb(terr, 1'h0);
	endtask : t_fill
	task automatic t_drain;
		@(posedge clk);
		mode <= RTF_MODE_DIRECT_FIFO;
		v = nxt;
		push(3);
		chkb(tae, 1'h0);
		pull(v);
		pull(v + 8'h01);
		chkb(tae, 1'h1);
		pull(v + 8'h02);
		pull(v + 8'h02);
		chkb(terr, 1'h1);
		recover(RTF_CMD_TX_FLUSH);
	endtask : t_drain
	task automatic t_retx;
		@(posedge clk);
		mode <= RTF_MODE_PACKET;
		retx <= 4'h1;
		v = nxt;
		push(2);
		pull(v);
		pull(v + 8'h01);
		@(posedge clk);
		tx_end <= 1'h1;
		@(posedge clk);
		tx_end <= 1'h0;
		pull(v);
		send(RTF_CMD_TX_FLUSH);
	endtask : t_retx
	task automatic t_rx;
		chkb(status[9], 1'h1);
		@(posedge clk);
		sel <= 1'h1;
		feed(8'h5a);
		feed(8'ha5);
		tick(2);
		chkb(raf, 1'h1);
		chkb(tae, 1'h0);
		rd(8'hff, 8'h5a);
		chkb(rae, 1'h1);
		rd(8'hff, 8'ha5);
		chkb(status[9], 1'h1);
		op(1'h0, 1'h0, 8'h00, 8'h00, RTF_CMD_RX_FLUSH);
		rd(8'hff, 8'h00);
		chkb(rerr, 1'h1);
		recover(RTF_CMD_RX_FLUSH);
		chkb(rerr, 1'h0);
	endtask : t_rx
	task automatic t_sleep;
		feed(8'h3c);
		slp();
		chkb(status[9], 1'h0);
		op(1'h1, 1'h0, 8'h79, 8'h00, 3'h0);
		idle();
		slp();
		chkb(status[9], 1'h1);
	endtask : t_sleep
	task automatic t_pin;
		logic [7:0] pat;
		pat = 8'hb4;
		@(posedge clk);
		mode <= RTF_MODE_DIRECT_PIN;
		for (int i = 0; i < 8; i++) begin
			for (n = 0; n < 20 && link.dclk !== 1'h1; n++)
				tick(1);
			for (n = 0; n < 20 && link.dclk !== 1'h0; n++)
				tick(1);
			@(posedge clk);
			u_bit <= pat[i];
			for (n = 0; n < 20 && tx_vld !== 1'h1; n++)
				tick(1);
			chkb(tx_bit, pat[i]);
		end
	endtask : t_pin
	// sixteen bits of x^9+x^5+1 from the all-ones seed, first bit first
	task automatic t_pn9;
		logic [15:0] seq;
		seq = 16'h0000;
		@(posedge clk);
		mode <= RTF_MODE_PN9;
		tick(1);
		for (int i = 0; i < 16; i++) begin
			for (n = 0; n < 20 && tx_vld !== 1'h1; n++)
				tick(1);
			seq[i] = tx_bit;
			tick(1);
		end
		chk(seq[7:0], 8'hff);
		chk(seq[15:8], 8'he1);
	endtask : t_pn9
	task automatic give_verdict;
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : give_verdict
	initial begin
		forever #50 clk = ~clk;
	end
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'h1;
		tick(2);
		t_regs();
		t_fill();
		t_drain();
		t_retx();
		t_rx();
		t_sleep();
		t_pin();
		t_pn9();
		give_verdict();
	end
	// run needs about 550 cycles
	initial begin
		#3000000;
		num_errors++;
		give_verdict();
	end
endmodule : test_radio_tx_rx_data_fifo
